// >>> logic/pcmsp_core.sv
//Contract
// RL1: Derive 256 kHz sequencing tick; divide found from master clock edges per frame.
// RL2: Host gives 256/512 kHz master clock rising-edge aligned to transmit sync.
// RL3: Host should align faster master clocks to transmit sync too.
// RL4: 8 kHz transmit sync, long or short, starts one transmit sample.
// RL5: Both syncs static for several frames powers the device down.
// RL6: Wake from sync power-down only once transmit sync clocks again.
// RL7: Transmit bit clock shifts transmit data; in synchronous modes receive too.
// RL8: Host bit clocks run between 256 and 4096 kHz in async modes.
// RL9: Transmit data floats except while shifting bits, and when powered down.
// RL10: Receive sync frames receive samples, may be asynchronous to transmit.
// RL11: Static receive bit clock selects mode; transmit bit clock then clocks receive.
// RL12: Receive bit clock low: 16-bit transfers, first four bits are sign.
// RL13: Receive bit clock high: 13-bit transmit, 16-bit receive with attenuation.
// RL14: Attenuation code gives 3 dB steps, 000 is 0 dB, 111 is 21 dB.
// RL15: Transmit sync alive, receive sync static: mute receive path.
// RL16: Non-inverting input strapped high disables gain amp, gain node is input.
// RL17: Power amp input at supply disables both power amps, outputs float.
// RL18: Bypass select removes the transmit high-pass stage, else keeps it.
// RL19: Samples are 13-bit two's complement, sign bit leading.
// RL20: After power-up transmit data floats at least two transmit sync periods.
// RL21: Shift out on bit clock rise, sample on fall, sign first.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`default_nettype none

module pcmsp_core #(
  parameter int unsigned IDLE_CYC = pcmsp_pkg::IDLE_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic mclk_i,
  input wire logic tx_frame_sync_i,
  input wire logic rx_frame_sync_i,
  input wire logic tx_bit_clock_i,
  input wire logic rx_bit_clock_or_mode_i,
  input wire logic rx_pcm_in_i,
  input wire logic power_down_in_n_i,
  input wire logic highpass_bypass_sel_i,
  input wire logic tx_noninv_input_sel_i,
  input wire logic power_amp_input_i,
  input wire logic [1:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic tx_pcm_out_o,
  output logic tx_pcm_out_oe_o,
  output logic [12:0] rx_sample_o,
  output logic rx_sample_valid_o,
  output logic [4:0] rx_atten_db_o,
  output logic rx_mute_o,
  output logic powered_down_o,
  output logic seq_tick_o,
  output logic tx_amp_en_o,
  output logic tx_gain_node_in_o,
  output logic power_amp_en_o,
  output logic highpass_en_o
);

  localparam int unsigned CW = pcmsp_pkg::CNT_W;
  localparam logic [CW-1:0] IDLE_LIM = CW'(IDLE_CYC);

  // ---------------------------------------------------------------
  // Edge detection and pin activity
  // ---------------------------------------------------------------
  logic tb_q_r;
  logic rb_q_r;
  logic mclk_q_r;
  logic txfs_q_r;
  logic [2:0] idle_w;

  wire logic tb_rise_w = tx_bit_clock_i & ~tb_q_r;
  wire logic tb_fall_w = ~tx_bit_clock_i & tb_q_r;
  wire logic rb_rise_w = rx_bit_clock_or_mode_i & ~rb_q_r;
  wire logic rb_fall_w = ~rx_bit_clock_or_mode_i & rb_q_r;
  wire logic mclk_rise_w = mclk_i & ~mclk_q_r;
  wire logic txfs_rise_w = tx_frame_sync_i & ~txfs_q_r;
  wire logic [2:0] act_sig_w = {rx_bit_clock_or_mode_i, rx_frame_sync_i,
                                tx_frame_sync_i};

  for (genvar g = 0; g < 3; g++) begin : g_act
    logic prev_r;
    logic [CW-1:0] cnt_r;
    assign idle_w[g] = (cnt_r == IDLE_LIM);
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        prev_r <= 1'b0;
        cnt_r <= '0;
      end else begin
        prev_r <= act_sig_w[g];
        if (act_sig_w[g] != prev_r) begin
          cnt_r <= '0;
        end else if (!idle_w[g]) begin
          cnt_r <= cnt_r + CW'(1);
        end
      end
    end
  end

  wire logic txfs_idle_w = idle_w[0];
  wire logic rxfs_idle_w = idle_w[1];
  wire logic rxb_idle_w = idle_w[2];

  // ---------------------------------------------------------------
  // Mode and clock selection
  // ---------------------------------------------------------------
  pcmsp_pkg::pcmsp_mode_t mode_r;
  pcmsp_pkg::pcmsp_mode_t mode_nxt;

  assign mode_nxt = !rxb_idle_w ? pcmsp_pkg::MODE_ASYNC : // RL11
                    rx_bit_clock_or_mode_i ? pcmsp_pkg::MODE_GAINADJ : // RL13
                    pcmsp_pkg::MODE_SIGNEXT; // RL12
  wire logic sync_w = (mode_r != pcmsp_pkg::MODE_ASYNC);
  wire logic signext_w = (mode_r == pcmsp_pkg::MODE_SIGNEXT);
  wire logic gainadj_w = (mode_r == pcmsp_pkg::MODE_GAINADJ);
  wire logic rx_rise_w = sync_w ? tb_rise_w : rb_rise_w; // RL7
  wire logic rx_fall_w = sync_w ? tb_fall_w : rb_fall_w; // RL7

  logic tx_start_w;
  logic tx_long_w;
  logic rx_start_w;

  pcmsp_framer #(
    .ON_FALL(1'b0)
  ) u_tx_framer (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .fs_i(tx_frame_sync_i),
    .rise_i(tb_rise_w),
    .fall_i(tb_fall_w),
    .start_o(tx_start_w),
    .long_o(tx_long_w)
  );

  pcmsp_framer #(
    .ON_FALL(1'b1)
  ) u_rx_framer (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .fs_i(rx_frame_sync_i),
    .rise_i(rx_rise_w),
    .fall_i(rx_fall_w),
    .start_o(rx_start_w),
    .long_o()
  );

  // ---------------------------------------------------------------
  // Power sequencing
  // ---------------------------------------------------------------
  pcmsp_pkg::pcmsp_pwr_t pwr_r;
  pcmsp_pkg::pcmsp_pwr_t pwr_nxt;
  logic [1:0] wake_cnt_r;

  wire logic pd_cond_w = ~power_down_in_n_i | (txfs_idle_w & rxfs_idle_w);
  wire logic run_w = (pwr_r == pcmsp_pkg::PS_RUN);
  wire logic down_w = (pwr_r == pcmsp_pkg::PS_DOWN);

  always_comb begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      pcmsp_pkg::PS_DOWN: begin
        if (power_down_in_n_i && !txfs_idle_w) begin
          pwr_nxt = pcmsp_pkg::PS_WAKE; // RL6
        end
      end
      pcmsp_pkg::PS_WAKE: begin
        if (pd_cond_w) begin
          pwr_nxt = pcmsp_pkg::PS_DOWN;
        end else if (txfs_rise_w &&
                     wake_cnt_r == pcmsp_pkg::WAKE_FRAMES) begin
          pwr_nxt = pcmsp_pkg::PS_RUN; // RL20
        end
      end
      pcmsp_pkg::PS_RUN: begin
        if (pd_cond_w) begin
          pwr_nxt = pcmsp_pkg::PS_DOWN; // RL5
        end
      end
      default: pwr_nxt = pcmsp_pkg::PS_DOWN;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwr_r <= pcmsp_pkg::PS_DOWN;
      wake_cnt_r <= 2'h0;
      mode_r <= pcmsp_pkg::MODE_ASYNC;
      tb_q_r <= 1'b0;
      rb_q_r <= 1'b0;
      mclk_q_r <= 1'b0;
      txfs_q_r <= 1'b0;
    end else begin
      pwr_r <= pwr_nxt;
      if (pwr_r != pcmsp_pkg::PS_WAKE) begin
        wake_cnt_r <= 2'h0;
      end else if (txfs_rise_w && wake_cnt_r != 2'h3) begin
        wake_cnt_r <= wake_cnt_r + 2'h1; // RL20
      end
      mode_r <= mode_nxt;
      tb_q_r <= tx_bit_clock_i;
      rb_q_r <= rx_bit_clock_or_mode_i;
      mclk_q_r <= mclk_i;
      txfs_q_r <= tx_frame_sync_i;
    end
  end

  // ---------------------------------------------------------------
  // Sequencing clock prescaler
  // ---------------------------------------------------------------
  // Relies on the master clock being rising-edge aligned to the
  // transmit sync at low rates, so the edge count per frame is exact
  logic [9:0] frame_mclk_r; // RL2
  logic [4:0] div_r;
  logic [4:0] seq_cnt_r;
  logic seq_tick_r;

  // An aligned master clock rise opens the frame and counts as its
  // first edge, so a divide of one still gives a full set of ticks
  wire logic [4:0] div_new_w = frame_mclk_r[9:pcmsp_pkg::SEQ_SHIFT];
  wire logic first_tick_w = mclk_rise_w & (div_new_w == 5'h01);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_mclk_r <= 10'h000;
      div_r <= 5'h00;
      seq_cnt_r <= 5'h00;
      seq_tick_r <= 1'b0;
    end else begin
      seq_tick_r <= 1'b0;
      if (txfs_rise_w) begin
        div_r <= div_new_w; // RL1
        frame_mclk_r <= {9'h000, mclk_rise_w};
        seq_cnt_r <= {4'h0, mclk_rise_w & ~first_tick_w};
        seq_tick_r <= first_tick_w; // RL1
      end else if (mclk_rise_w) begin
        if (frame_mclk_r != 10'h3FF) begin
          frame_mclk_r <= frame_mclk_r + 10'h001;
        end
        if (div_r != 5'h00 && seq_cnt_r == div_r - 5'h01) begin
          seq_cnt_r <= 5'h00;
          seq_tick_r <= 1'b1; // RL1
        end else begin
          seq_cnt_r <= seq_cnt_r + 5'h01;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Transmit shifter
  // ---------------------------------------------------------------
  logic [12:0] txdata_r;
  logic [15:0] tx_sh_r;
  logic [4:0] tx_cnt_r;
  logic tx_out_r;
  logic tx_oe_r;

  // Sign extension keeps the two's complement value intact
  wire logic [15:0] tx_word_w = signext_w ? {{3{txdata_r[12]}}, txdata_r}
                                          : {txdata_r, 3'h0}; // RL12 RL19
  wire logic [4:0] tx_len_w = signext_w ? pcmsp_pkg::LEN_WIDE
                                        : pcmsp_pkg::LEN_VOICE; // RL13

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_sh_r <= 16'h0000;
      tx_cnt_r <= 5'h00;
      tx_out_r <= 1'b0;
      tx_oe_r <= 1'b0;
    end else if (!run_w) begin
      tx_oe_r <= 1'b0; // RL9 RL20
      tx_cnt_r <= 5'h00;
    end else if (tx_start_w) begin
      tx_sh_r <= {tx_word_w[14:0], 1'b0}; // RL4
      tx_out_r <= tx_word_w[15]; // RL21
      tx_oe_r <= 1'b1;
      tx_cnt_r <= tx_len_w - 5'h01;
    end else if (tb_rise_w && tx_oe_r) begin
      if (tx_cnt_r != 5'h00) begin
        tx_out_r <= tx_sh_r[15]; // RL7
        tx_sh_r <= {tx_sh_r[14:0], 1'b0};
        tx_cnt_r <= tx_cnt_r - 5'h01;
      end else begin
        tx_oe_r <= 1'b0; // RL9
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive shifter
  // ---------------------------------------------------------------
  logic [15:0] rx_sh_r;
  logic [4:0] rx_cnt_r;
  logic rx_busy_r;
  logic [12:0] rx_sample_r;
  logic [2:0] rx_code_r;
  logic [4:0] rx_atten_r;
  logic rx_valid_r;

  wire logic [4:0] rx_len_w = sync_w ? pcmsp_pkg::LEN_WIDE
                                     : pcmsp_pkg::LEN_VOICE; // RL12 RL13
  wire logic rx_take_w = rx_busy_r & rx_fall_w & ~rx_start_w;
  wire logic rx_done_w = rx_take_w & (rx_cnt_r == rx_len_w - 5'h01);
  wire logic [15:0] rx_word_w = {rx_sh_r[14:0], rx_pcm_in_i};
  // Sign-extended and plain words both end in the 13 voice bits
  wire logic [12:0] rx_voice_w = gainadj_w ? rx_word_w[15:3]
                                           : rx_word_w[12:0];
  wire logic [2:0] rx_code_w = gainadj_w ? rx_word_w[2:0] : 3'h0;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_sh_r <= 16'h0000;
      rx_cnt_r <= 5'h00;
      rx_busy_r <= 1'b0;
      rx_sample_r <= 13'h0000;
      rx_code_r <= 3'h0;
      rx_atten_r <= 5'h00;
      rx_valid_r <= 1'b0;
    end else begin
      rx_valid_r <= 1'b0;
      if (down_w) begin
        rx_busy_r <= 1'b0;
      end else if (rx_start_w) begin
        rx_sh_r <= {15'h0000, rx_pcm_in_i}; // RL10 RL21
        rx_cnt_r <= 5'h01;
        rx_busy_r <= 1'b1;
      end else if (rx_take_w) begin
        rx_sh_r <= rx_word_w;
        rx_cnt_r <= rx_cnt_r + 5'h01;
        if (rx_done_w) begin
          rx_busy_r <= 1'b0;
          rx_sample_r <= rx_voice_w; // RL19
          rx_code_r <= rx_code_w; // RL13
          rx_atten_r <= {2'h0, rx_code_w} * pcmsp_pkg::ATTEN_STEP_DB; // RL14
          rx_valid_r <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Analog enables and mute
  // ---------------------------------------------------------------
  logic mute_r;
  logic pd_r;
  logic tx_amp_r;
  logic tg_in_r;
  logic pa_r;
  logic hp_r;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mute_r <= 1'b0;
      pd_r <= 1'b1;
      tx_amp_r <= 1'b0;
      tg_in_r <= 1'b0;
      pa_r <= 1'b0;
      hp_r <= 1'b1;
    end else begin
      mute_r <= rxfs_idle_w & ~txfs_idle_w; // RL15
      pd_r <= down_w;
      tx_amp_r <= ~down_w & ~tx_noninv_input_sel_i; // RL16
      tg_in_r <= tx_noninv_input_sel_i; // RL16
      pa_r <= ~down_w & ~power_amp_input_i; // RL17
      hp_r <= ~highpass_bypass_sel_i; // RL18
    end
  end

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  logic [15:0] rdata_r;

  wire logic [15:0] status_w = {5'h00, div_r, tx_long_w, mute_r,
                                mode_r, pd_r};
  wire logic [15:0] rd_mux_w =
    (reg_addr_i == pcmsp_pkg::ADDR_TXDATA) ? {3'h0, txdata_r} :
    (reg_addr_i == pcmsp_pkg::ADDR_RXDATA) ? {rx_code_r, rx_sample_r} :
    (reg_addr_i == pcmsp_pkg::ADDR_STATUS) ? status_w : 16'h0000;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      txdata_r <= pcmsp_pkg::TXDATA_RST;
      rdata_r <= 16'h0000;
    end else begin
      if (reg_wr_i && reg_addr_i == pcmsp_pkg::ADDR_TXDATA) begin
        txdata_r <= reg_wdata_i[12:0];
      end
      rdata_r <= reg_rd_i ? rd_mux_w : 16'h0000;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign tx_pcm_out_o = tx_out_r;
  assign tx_pcm_out_oe_o = tx_oe_r;
  assign rx_sample_o = rx_sample_r;
  assign rx_sample_valid_o = rx_valid_r;
  assign rx_atten_db_o = rx_atten_r;
  assign rx_mute_o = mute_r;
  assign powered_down_o = pd_r;
  assign seq_tick_o = seq_tick_r;
  assign tx_amp_en_o = tx_amp_r;
  assign tx_gain_node_in_o = tg_in_r;
  assign power_amp_en_o = pa_r;
  assign highpass_en_o = hp_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  oe_powerdown_a: assert property ( // RL9
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    !run_w |=> !tx_pcm_out_oe_o)
    else $error("transmit output driven outside run state");

  wake_quiet_a: assert property ( // RL20
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (pwr_r == pcmsp_pkg::PS_WAKE) && !txfs_rise_w |=> !tx_pcm_out_oe_o)
    else $error("transmit output driven during wake-up");

  pd_entry_a: assert property ( // RL5
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    run_w && txfs_idle_w && rxfs_idle_w |=> down_w ##1 powered_down_o)
    else $error("static syncs did not power down");

  wake_needs_fs_a: assert property ( // RL6
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    down_w && txfs_idle_w |=> down_w)
    else $error("woke without transmit sync");

  oe_on_edge_a: assert property ( // RL21
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(tx_pcm_out_oe_o) |-> $past(tb_rise_w) && $past(tx_start_w))
    else $error("transmit output started off a bit clock rise");

  sign_bits_a: assert property ( // RL12
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    tx_start_w && run_w && signext_w |=>
      tx_pcm_out_o == tx_sh_r[15] && tx_sh_r[15] == tx_sh_r[14] &&
      tx_sh_r[14] == tx_sh_r[13])
    else $error("sign extension bits differ");

  atten_step_a: assert property ( // RL14
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    rx_valid_r |->
      rx_atten_db_o == {1'b0, rx_code_r, 1'b0} + {2'h0, rx_code_r})
    else $error("attenuation not in 3 dB steps");

  half_mute_a: assert property ( // RL15
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    rxfs_idle_w && !txfs_idle_w |=> rx_mute_o)
    else $error("receive path not muted in half-channel");

  pa_off_a: assert property ( // RL17
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    power_amp_input_i |=> !power_amp_en_o)
    else $error("power amps enabled with input at supply");

  hp_bypass_a: assert property ( // RL18
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    highpass_bypass_sel_i[*2] |-> !highpass_en_o)
    else $error("high-pass stage kept while bypassed");

endmodule // pcmsp_core

`default_nettype wire

// >>> logic/pcmsp_framer.sv
`default_nettype none

module pcmsp_framer #(
  parameter bit ON_FALL = 1'b0
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic fs_i,
  input wire logic rise_i,
  input wire logic fall_i,
  output logic start_o,
  output logic long_o
);

  logic fs_q_r;
  logic pend_r;
  logic seen_r;
  logic wide_r;
  logic long_r;

  wire logic fs_rise_w = fs_i & ~fs_q_r;
  wire logic fs_fall_w = ~fs_i & fs_q_r;
  wire logic pend_w = pend_r | fs_rise_w;
  wire logic act_edge_w = ON_FALL ? fall_i : rise_i;

  // Long sync: first bit with the sync; short: one bit after it
  assign start_o = act_edge_w & (long_r ? (pend_w & fs_i) : seen_r);
  assign long_o = long_r;

  // Format is learned from the previous sync width, so the very
  // first short frame after reset is taken as long
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fs_q_r <= 1'b0;
      pend_r <= 1'b0;
      seen_r <= 1'b0;
      wide_r <= 1'b0;
      long_r <= 1'b1;
    end else begin
      fs_q_r <= fs_i;
      pend_r <= pend_w & ~start_o;
      if (start_o) begin
        seen_r <= 1'b0;
      end else if (fall_i & pend_w & fs_i) begin
        seen_r <= 1'b1;
      end
      if (fs_rise_w) begin
        wide_r <= 1'b0;
      end else if (fs_i & rise_i) begin
        wide_r <= 1'b1;
      end
      if (fs_fall_w) begin
        long_r <= wide_r;
      end
    end
  end

endmodule // pcmsp_framer

`default_nettype wire

// >>> logic/pcmsp_pkg.sv
`default_nettype none

package pcmsp_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned FRAME_PERIOD_NS = 125000;
  localparam int unsigned FRAME_CYC = FRAME_PERIOD_NS / CLK_PERIOD_NS;
  // Frames without a toggle before a pin counts as static
  localparam int unsigned IDLE_FRAMES = 4;
  localparam int unsigned IDLE_CYC = IDLE_FRAMES * FRAME_CYC;
  localparam int unsigned CNT_W = 17;
  // Frame syncs the output stays quiet for after power-up
  localparam logic [1:0] WAKE_FRAMES = 2'h2;
  // Master clock edges per frame at 256 kHz is 32: divide = edges >> 5
  localparam int unsigned SEQ_SHIFT = 5;

  // ---------------------------------------------------------------
  // Word formats
  // ---------------------------------------------------------------
  localparam logic [4:0] LEN_VOICE = 5'h0D;
  localparam logic [4:0] LEN_WIDE = 5'h10;
  localparam logic [4:0] ATTEN_STEP_DB = 5'h03;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [1:0] ADDR_TXDATA = 2'h0;
  localparam logic [1:0] ADDR_RXDATA = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam logic [12:0] TXDATA_RST = 13'h0000;

  typedef enum logic [2:0] {
    MODE_ASYNC = 3'b001,
    MODE_SIGNEXT = 3'b010,
    MODE_GAINADJ = 3'b100
  } pcmsp_mode_t;

  typedef enum logic [2:0] {
    PS_DOWN = 3'b001,
    PS_WAKE = 3'b010,
    PS_RUN = 3'b100
  } pcmsp_pwr_t;

endpackage

`default_nettype wire

// >>> test/pcmsp_host.sv
`default_nettype none

// Highway controller: bit clock of 32 sys cycles, 32 bits a frame
module pcmsp_host (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic tx_en_i,
  input wire logic rx_en_i,
  input wire logic short_i,
  input wire logic [1:0] rmode_i,
  input wire logic [15:0] rx_word_i,
  input wire logic [4:0] rx_len_i,
  input wire logic tx_dat_i,
  input wire logic tx_oe_i,
  output logic bit_clk_o,
  output logic tx_fs_o,
  output logic rx_fs_o,
  output logic rx_clk_o,
  output logic rx_dat_o,
  output logic [9:0] cyc_o,
  output logic [15:0] tx_cap_o,
  output logic [4:0] tx_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic fs;
  // ----
  // Framing
  // ----
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cyc_o <= 10'h000;
    end else begin
      cyc_o <= cyc_o + 10'h001;
    end
  end
  assign bit_clk_o = ~cyc_o[4];
  // Long spans two rises; short covers only the last fall of a frame
  assign fs = short_i ? (cyc_o >= 10'h3E8) : (cyc_o < 10'h040);
  assign tx_fs_o = tx_en_i & fs;
  assign rx_fs_o = rx_en_i & fs;
  assign rx_clk_o = (rmode_i == 2'h0) ? bit_clk_o : rmode_i[1];
  // Past the word the line toggles, so a late sample cannot match by luck
  assign rx_dat_o = (cyc_o[9:5] < rx_len_i) ?
    rx_word_i[~cyc_o[8:5]] : cyc_o[0];
  // ----
  // Transmit capture
  // ----
  always_ff @(posedge clk_sys_i) begin
    if (cyc_o == 10'h002) begin
      tx_n_o <= 5'h00;
      tx_cap_o <= 16'h0000;
    end else if (cyc_o[4:0] == 5'h10 && tx_oe_i) begin
      tx_cap_o <= {tx_cap_o[14:0], tx_dat_i};
      tx_n_o <= tx_n_o + 5'h01;
    end
  end
endmodule // pcmsp_host

`default_nettype wire

// >>> test/tb_pcm_codec_serial_port.sv
`default_nettype none

module tb_pcm_codec_serial_port;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic pd_n = 1'b1;
  logic hpb = 1'b0;
  logic tnis = 1'b0;
  logic pai = 1'b0;
  logic tx_en = 1'b1;
  logic rx_en = 1'b1;
  logic short_s = 1'b0;
  logic [1:0] rmode = 2'h0;
  logic [15:0] rx_word = 16'h0000;
  logic [4:0] rx_len = 5'h0D;
  logic [1:0] reg_addr = 2'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] rdata, tx_cap;
  logic bit_clk, txfs, rxfs, rx_clk, rx_dat, tx_dat, oe, mute, pd, hp_en;
  logic amp_en, gnode, pa_en;
  logic tick, rvalid;
  int ticks = 0;
  int valids = 0;
  logic [12:0] rx_sample;
  logic [4:0] atten, tx_n;
  logic [9:0] cyc;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;

  pcmsp_host host_u (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .tx_en_i(tx_en), .rx_en_i(rx_en), .short_i(short_s), .rmode_i(rmode),
    .rx_word_i(rx_word), .rx_len_i(rx_len), .tx_dat_i(tx_dat),
    .tx_oe_i(oe), .bit_clk_o(bit_clk), .tx_fs_o(txfs), .rx_fs_o(rxfs),
    .rx_clk_o(rx_clk), .rx_dat_o(rx_dat), .cyc_o(cyc),
    .tx_cap_o(tx_cap), .tx_n_o(tx_n));
  // Master clock tied to the bit clock, rising with the long transmit sync
  pcmsp_core #(.IDLE_CYC(3000)) dut_u (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .mclk_i(bit_clk),
    .tx_frame_sync_i(txfs), .rx_frame_sync_i(rxfs),
    .tx_bit_clock_i(bit_clk), .rx_bit_clock_or_mode_i(rx_clk),
    .rx_pcm_in_i(rx_dat), .power_down_in_n_i(pd_n),
    .highpass_bypass_sel_i(hpb), .tx_noninv_input_sel_i(tnis),
    .power_amp_input_i(pai), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(rdata), .tx_pcm_out_o(tx_dat), .tx_pcm_out_oe_o(oe),
    .rx_sample_o(rx_sample), .rx_sample_valid_o(rvalid),
    .rx_atten_db_o(atten), .rx_mute_o(mute), .powered_down_o(pd),
    .seq_tick_o(tick), .tx_amp_en_o(amp_en), .tx_gain_node_in_o(gnode),
    .power_amp_en_o(pa_en), .highpass_en_o(hp_en));

  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // ----
  // Helpers
  // ----
  task automatic end_of_test;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Pulse counters; updated late so a task snapshot never races them
  always @(posedge clk_sys_i) begin
    if (tick === 1'b1) begin
      ticks <= ticks + 1;
    end
    if (rvalid === 1'b1) begin
      valids <= valids + 1;
    end
  end

  // Scenarios run about 54 frames of 1024 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      end_of_test;
    end
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr <= 1'b0;
  endtask

  task automatic rdchk(input logic [1:0] a, input logic [15:0] e);
    @(posedge clk_sys_i);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd <= 1'b0;
    #1;
    chk(rdata, e);
    @(posedge clk_sys_i);
  endtask

  // Waits until cycle 960 of a frame has come round the given number of times
  task automatic fr(input int n);
    repeat (n) begin
      @(posedge clk_sys_i);
      while (cyc !== 10'h3C0)
        @(posedge clk_sys_i);
    end
  endtask

  // ----
  // Scenarios
  // ----
  task automatic t_async;
    int t0;
    int v0;
    wr(2'h0, 16'h1000);
    rx_word <= 16'h8008;
    fr(4);
    t0 = ticks;
    v0 = valids;
    fr(1);
    chk(16'(ticks - t0), 16'h0020);
    chk(16'(valids - v0), 16'h0001);
    chk(16'(tx_n), 16'h000D);
    chk(tx_cap, 16'h1000);
    chk(16'(oe), 16'h0000);
    chk(16'(rx_sample), 16'h1001);
    rdchk(2'h2, 16'h0062);
  endtask

  task automatic t_pins;
    for (int i = 0; i < 8; i++) begin
      {hpb, tnis, pai} <= 3'(i);
      repeat (3) @(posedge clk_sys_i);
      chk(16'(hp_en), 16'(!i[2]));
      chk(16'(amp_en), 16'(!i[1]));
      chk(16'(gnode), 16'(i[1]));
      chk(16'(pa_en), 16'(!i[0]));
    end
    {hpb, tnis, pai} <= 3'h0;
  endtask

  task automatic t_short;
    short_s <= 1'b1;
    wr(2'h0, 16'h0FFF);
    rx_word <= 16'h55E0;
    fr(3);
    chk(16'(tx_n), 16'h000D);
    chk(tx_cap, 16'h0FFF);
    chk(16'(rx_sample), 16'h0ABC);
    rdchk(2'h2, 16'h0042);
    short_s <= 1'b0;
    fr(2);
  endtask

  task automatic t_mute;
    rx_en <= 1'b0;
    fr(5);
    chk(16'(mute), 16'h0001);
    chk(16'(pd), 16'h0000);
    rdchk(2'h2, 16'h0072);
    rx_en <= 1'b1;
    fr(2);
    chk(16'(mute), 16'h0000);
  endtask

  task automatic t_signext;
    rmode <= 2'h1;
    rx_len <= 5'h10;
    rx_word <= 16'hF234;
    wr(2'h0, 16'h1555);
    fr(5);
    rdchk(2'h2, 16'h0064);
    chk(16'(tx_n), 16'h0010);
    chk(tx_cap, 16'hF555);
    chk(16'(rx_sample), 16'h1234);
  endtask

  task automatic t_gain;
    rmode <= 2'h2;
    rx_word <= 16'h7FF8;
    wr(2'h0, 16'h0ABC);
    fr(5);
    rdchk(2'h2, 16'h0068);
    chk(16'(tx_n), 16'h000D);
    chk(tx_cap, 16'h0ABC);
    for (int i = 0; i < 8; i++) begin
      rx_word <= {13'h0FFF, 3'(i)};
      fr(1);
      chk(16'(atten), 16'(i * 3));
      chk(16'(rx_sample), 16'h0FFF);
    end
    rdchk(2'h1, 16'hEFFF);
  endtask

  task automatic t_pdpin;
    pd_n <= 1'b0;
    fr(1);
    chk(16'(pd), 16'h0001);
    chk(16'(tx_n), 16'h0000);
    pd_n <= 1'b1;
    fr(1);
    chk(16'(tx_n), 16'h0000);
    fr(1);
    chk(16'(tx_n), 16'h0000);
    fr(2);
    chk(16'(tx_n), 16'h000D);
  endtask

  task automatic t_syncpd;
    tx_en <= 1'b0;
    rx_en <= 1'b0;
    fr(5);
    chk(16'(pd), 16'h0001);
    rx_en <= 1'b1;
    fr(4);
    chk(16'(pd), 16'h0001);
    tx_en <= 1'b1;
    fr(5);
    chk(16'(pd), 16'h0000);
    chk(16'(tx_n), 16'h000D);
  endtask

  initial begin
    repeat (20) @(posedge clk_sys_i);
    chk(16'(pd), 16'h0001);
    chk(16'(hp_en), 16'h0001);
    rst_n_i <= 1'b1;
    wr(2'h3, 16'hFFFF);
    rdchk(2'h3, 16'h0000);
    rdchk(2'h0, 16'h0000);
    t_async;
    t_pins;
    t_short;
    t_mute;
    t_signext;
    t_gain;
    t_pdpin;
    t_syncpd;
    end_of_test;
  end
endmodule // tb_pcm_codec_serial_port

`default_nettype wire
